// File: rtl/adc_monitor_pkg.sv
// constants, register map and state codes for the monitor converter control
// assumes a 125 MHz system clock and a 16-bit register port
package adc_monitor_pkg;

  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 16;
  localparam int          RES_W           = 16;
  localparam int          NUM_CH_DEF      = 8;

  // register offsets
  localparam logic [7:0]  ADDR_CTRL       = 8'h00;
  localparam logic [7:0]  ADDR_CHAN_DIS   = 8'h01;
  localparam logic [7:0]  ADDR_STATUS     = 8'h02;
  localparam logic [7:0]  ADDR_FLAG       = 8'h03;
  localparam logic [7:0]  ADDR_MASK       = 8'h04;
  localparam logic [7:0]  ADDR_RESULT     = 8'h10;

  // control field positions
  localparam int          CTRL_EN_BIT     = 0;
  localparam int          CTRL_ONESHOT_BIT = 1;
  localparam int          CTRL_AVG_BIT    = 2;
  localparam int          CTRL_SEED_BIT   = 3;
  localparam int          CTRL_SPEED_LSB  = 4;
  localparam int          CTRL_IBAT_BIT   = 6;

  // status field positions
  localparam int          STAT_DONE_BIT   = 0;
  localparam int          STAT_BUSY_BIT   = 1;
  localparam int          STAT_SUPPLY_BIT = 2;
  localparam int          STAT_PAUSE_BIT  = 3;
  localparam int          STAT_HIGHZ_BIT  = 4;
  localparam int          FLAG_DONE_BIT   = 0;
  localparam int          MASK_DONE_BIT   = 0;

  // reset values
  localparam logic [15:0] CTRL_RESET      = 16'h0000;
  localparam logic [15:0] CHAN_DIS_RESET  = 16'h0000;
  localparam logic [15:0] MASK_RESET      = 16'h0000;
  localparam logic [15:0] RESULT_RESET    = 16'h0000;

  // channel assignment
  localparam int          CHARGE_CUR_CH   = 2;
  localparam int          IBAT_CH         = 3;
  localparam int          THERM_CH        = 6;

  // interrupt pulse timing
  localparam int          CLK_PERIOD_NS   = 8;
  localparam int          INT_PULSE_US    = 256;
  localparam int          INT_PULSE_CYC   = (INT_PULSE_US * 1000 + CLK_PERIOD_NS - 1)
                                            / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_START = 2'b01,
    ST_WAIT  = 2'b10
  } pass_state_t;

endpackage : adc_monitor_pkg

// File: rtl/int_pulse_gen.sv
// fixed-width active-low notification pulse generator
// assumes trig_i is a one-cycle pulse from logic on sys_clk_i
`timescale 1ns/1ps
`default_nettype none

module int_pulse_gen #(
  parameter int CYC = 32000
) (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic trig_i,
  output logic      int_n_o
);

  localparam int CNT_W = $clog2(CYC + 1);

  logic [CNT_W-1:0] cnt_q;
  logic             int_n_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cnt_q   <= '0;
      int_n_q <= 1'b1;
    end else if (trig_i && cnt_q == '0) begin
      cnt_q   <= CNT_W'(CYC);
      int_n_q <= 1'b0;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - CNT_W'(1);
      if (cnt_q == CNT_W'(1)) begin
        int_n_q <= 1'b1;
      end
    end
  end

  assign int_n_o = int_n_q;

  a_pulse_start: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    trig_i && int_n_o |=> !int_n_o && cnt_q == CNT_W'(CYC))
    else $error("notification pulse did not start");

endmodule : int_pulse_gen
`default_nettype wire

// File: rtl/adc_monitor_ctrl.sv
// control of the charger monitor converter: passes, gating, results, done event
// assumes an analog core on sys_clk_i answering conv_start_o with conv_done_i
// Summary of operation
// - one converter, 16-bit results, software enable
// - one-shot pass end clears enable
// - optional averaging, seed from stored or fresh
// - run only with a valid supply
// - early enable waits for supply, then starts
// - high impedance mode still converts
// - thermistor channel raises battery-only threshold
// - speed change redoes current channel
// - disabled channel keeps last result
// - disable mid-conversion finishes, skips next pass
// - all disabled: powered, idle, ready
// - one-shot end sets done, masked interrupt
// - continuous mode keeps done at zero
// - faults never stop; only software disable
// - adapter plug-in pauses until setup done
// - thermistor channel forces bias regulator on
// - charge current reads zero when not charging
// - battery current valid only with amp enabled
// - interrupt is fixed-length low pulse
// - flags clear on read, set on edge
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module adc_monitor_ctrl
  import adc_monitor_pkg::*;
#(
  parameter int NUM_CH    = NUM_CH_DEF,
  parameter int PULSE_CYC = INT_PULSE_CYC,
  parameter int CH_W      = $clog2(NUM_CH)
) (
  input  wire logic              sys_clk_i,
  input  wire logic              rst_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  input  wire logic              ac_valid_i,
  input  wire logic              bus_valid_i,
  input  wire logic              bat_above_low_i,
  input  wire logic              bat_above_high_i,
  input  wire logic              high_impedance_input_mode_i,
  input  wire logic              adapter_plugin_i,
  input  wire logic              input_setup_done_i,
  input  wire logic              battery_only_i,
  input  wire logic              charge_current_zero_i,
  output logic                   conv_start_o,
  output logic                   conv_abort_o,
  output logic      [CH_W-1:0]   conv_chan_o,
  output logic      [1:0]        sample_speed_o,
  input  wire logic              conv_done_i,
  input  wire logic [RES_W-1:0]  conv_data_i,
  output logic                   adc_power_en_o,
  output logic                   internal_bias_regulator_en_o,
  output logic                   current_sense_amp_en_o,
  output logic                   int_n_o
);

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  pass_state_t       state_q;
  logic              conv_en_q;
  logic              oneshot_q;
  logic              avg_en_q;
  logic              seed_sel_q;
  logic [1:0]        speed_q;
  logic [1:0]        run_speed_q;
  logic              ibat_en_q;
  logic [NUM_CH-1:0] chan_dis_q;
  logic              done_mask_q;
  logic              done_stat_q;
  logic              done_flag_q;
  logic              pause_q;
  logic              amp_en_q;
  logic [CH_W-1:0]   cur_q;
  logic [NUM_CH-1:0] seeded_q;
  logic [RES_W-1:0]  res_q [NUM_CH];
  logic [DATA_W-1:0] rdata_q;
  logic [3:0]        sync_a_q;
  logic [3:0]        sync_b_q;

  logic              wr_ctrl;
  logic              run_ok;
  logic              hold;
  logic              pass_end;
  logic              done_set;
  logic              chan_ok;
  logic [CH_W:0]     first_ch;
  logic [CH_W:0]     next_ch;
  logic [RES_W:0]    avg_sum;
  logic [RES_W-1:0]  new_res;

  // lowest enabled channel at or above from
  function automatic logic [CH_W:0] find_enabled(input logic [NUM_CH-1:0] dis,
                                                 input int from);
    logic [CH_W:0] r;
    r = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (i >= from && !dis[i]) begin
        r = {1'b1, CH_W'(i)};
      end
    end
    return r;
  endfunction : find_enabled

  // ----------------------------------------------------------------
  // supply comparators and gating
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sync_a_q <= 4'h0;
      sync_b_q <= 4'h0;
    end else begin
      sync_a_q <= {bat_above_high_i, bat_above_low_i, bus_valid_i, ac_valid_i};
      sync_b_q <= sync_a_q;
    end
  end

  // any valid supply; thermistor raises battery threshold
  assign run_ok = sync_b_q[0] | sync_b_q[1]
                | (chan_dis_q[THERM_CH] ? sync_b_q[2] : sync_b_q[3]);
  // faults and input mode play no part in gating
  assign hold   = !run_ok | pause_q;

  // pause from plug-in until input setup finished
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pause_q <= 1'b0;
    end else if (adapter_plugin_i) begin
      pause_q <= 1'b1;
    end else if (input_setup_done_i) begin
      pause_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  assign wr_ctrl = reg_wr_i && reg_addr_i == ADDR_CTRL;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      oneshot_q   <= CTRL_RESET[CTRL_ONESHOT_BIT];
      avg_en_q    <= CTRL_RESET[CTRL_AVG_BIT];
      seed_sel_q  <= CTRL_RESET[CTRL_SEED_BIT];
      speed_q     <= CTRL_RESET[CTRL_SPEED_LSB +: 2];
      ibat_en_q   <= CTRL_RESET[CTRL_IBAT_BIT];
      chan_dis_q  <= CHAN_DIS_RESET[NUM_CH-1:0];
      done_mask_q <= MASK_RESET[MASK_DONE_BIT];
    end else if (reg_wr_i) begin
      if (reg_addr_i == ADDR_CTRL) begin
        oneshot_q  <= reg_wdata_i[CTRL_ONESHOT_BIT];
        avg_en_q   <= reg_wdata_i[CTRL_AVG_BIT];
        seed_sel_q <= reg_wdata_i[CTRL_SEED_BIT];
        speed_q    <= reg_wdata_i[CTRL_SPEED_LSB +: 2];
        ibat_en_q  <= reg_wdata_i[CTRL_IBAT_BIT];
      end
      if (reg_addr_i == ADDR_CHAN_DIS) begin
        chan_dis_q <= reg_wdata_i[NUM_CH-1:0];
      end
      if (reg_addr_i == ADDR_MASK) begin
        done_mask_q <= reg_wdata_i[MASK_DONE_BIT];
      end
    end
  end

  // software enable; cleared by hardware after one-shot pass
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      conv_en_q <= CTRL_RESET[CTRL_EN_BIT];
    end else if (wr_ctrl) begin
      conv_en_q <= reg_wdata_i[CTRL_EN_BIT];
    end else if (pass_end && oneshot_q) begin
      conv_en_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // pass sequencer
  // ----------------------------------------------------------------
  assign first_ch = find_enabled(chan_dis_q, 0);
  assign next_ch  = find_enabled(chan_dis_q, int'(cur_q) + 1);
  assign chan_ok  = conv_en_q && !hold;

  always_comb begin
    conv_start_o = 1'b0;
    conv_abort_o = 1'b0;
    pass_end     = 1'b0;
    case (state_q)
      ST_START: begin
        conv_start_o = chan_ok;
      end
      ST_WAIT: begin
        if (!chan_ok || speed_q != run_speed_q) begin
          conv_abort_o = 1'b1;
        end else if (conv_done_i && !next_ch[CH_W]) begin
          pass_end = 1'b1;
        end
      end
      default: begin
        conv_start_o = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_q     <= ST_IDLE;
      cur_q       <= '0;
      run_speed_q <= CTRL_RESET[CTRL_SPEED_LSB +: 2];
    end else begin
      case (state_q)
        ST_IDLE: begin
          // idle while every channel is disabled
          if (conv_en_q && first_ch[CH_W]) begin
            cur_q   <= first_ch[CH_W-1:0];
            state_q <= ST_START;
          end
        end
        ST_START: begin
          // wait here until a supply is valid
          if (!conv_en_q) begin
            state_q <= ST_IDLE;
          end else if (!hold) begin
            run_speed_q <= speed_q;
            state_q     <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (!conv_en_q) begin
            state_q <= ST_IDLE;
          end else if (hold || speed_q != run_speed_q) begin
            // redo current channel at new speed
            state_q <= ST_START;
          end else if (conv_done_i) begin
            // ascending order; disables seen next pick
            if (next_ch[CH_W]) begin
              cur_q   <= next_ch[CH_W-1:0];
              state_q <= ST_START;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // result storage
  // ----------------------------------------------------------------
  // average with stored value unless fresh seed pending
  assign avg_sum = {1'b0, res_q[cur_q]} + {1'b0, conv_data_i};

  always_comb begin
    new_res = conv_data_i;
    if (avg_en_q && (!seed_sel_q || seeded_q[cur_q])) begin
      new_res = avg_sum[RES_W:1];
    end
    // charge current reads zero outside charge or discharge
    if (int'(cur_q) == CHARGE_CUR_CH && charge_current_zero_i) begin
      new_res = '0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_CH; i++) begin
        res_q[i] <= RESULT_RESET;
      end
      seeded_q <= '0;
    end else begin
      // only a completed conversion touches a result
      if (state_q == ST_WAIT && !conv_abort_o && conv_done_i) begin
        // battery current stored only with amp running
        if (int'(cur_q) != IBAT_CH || amp_en_q) begin
          res_q[cur_q]    <= new_res;
          seeded_q[cur_q] <= avg_en_q;
        end
      end
      if (!avg_en_q) begin
        seeded_q <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // done status, flag and notification
  // ----------------------------------------------------------------
  // set at one-shot pass end; held low in continuous
  assign done_set = pass_end && oneshot_q && !done_stat_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      done_stat_q <= 1'b0;
    end else if (pass_end && oneshot_q) begin
      done_stat_q <= 1'b1;
    end else if (!oneshot_q || (state_q == ST_IDLE && conv_en_q)) begin
      done_stat_q <= 1'b0;
    end
  end

  // set on rising status, cleared by reading, set wins
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      done_flag_q <= 1'b0;
    end else if (done_set) begin
      done_flag_q <= 1'b1;
    end else if (reg_rd_i && reg_addr_i == ADDR_FLAG) begin
      done_flag_q <= 1'b0;
    end
  end

  int_pulse_gen #(
    .CYC (PULSE_CYC)
  ) i_int_pulse_gen (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .trig_i    (done_set && !done_mask_q),
    .int_n_o   (int_n_o)
  );

  // ----------------------------------------------------------------
  // analog side controls
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      amp_en_q <= 1'b0;
    end else begin
      // amp off in battery-only unless enabled
      amp_en_q <= !battery_only_i || ibat_en_q;
    end
  end

  assign adc_power_en_o               = conv_en_q;
  assign internal_bias_regulator_en_o = conv_en_q && !chan_dis_q[THERM_CH];
  assign current_sense_amp_en_o       = amp_en_q;
  assign conv_chan_o                  = cur_q;
  assign sample_speed_o               = speed_q;

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= '0;
      if (reg_rd_i) begin
        if (reg_addr_i == ADDR_CTRL) begin
          rdata_q[CTRL_EN_BIT]           <= conv_en_q;
          rdata_q[CTRL_ONESHOT_BIT]      <= oneshot_q;
          rdata_q[CTRL_AVG_BIT]          <= avg_en_q;
          rdata_q[CTRL_SEED_BIT]         <= seed_sel_q;
          rdata_q[CTRL_SPEED_LSB +: 2]   <= speed_q;
          rdata_q[CTRL_IBAT_BIT]         <= ibat_en_q;
        end else if (reg_addr_i == ADDR_CHAN_DIS) begin
          rdata_q[NUM_CH-1:0] <= chan_dis_q;
        end else if (reg_addr_i == ADDR_STATUS) begin
          rdata_q[STAT_DONE_BIT]   <= done_stat_q;
          rdata_q[STAT_BUSY_BIT]   <= state_q != ST_IDLE;
          rdata_q[STAT_SUPPLY_BIT] <= run_ok;
          rdata_q[STAT_PAUSE_BIT]  <= pause_q;
          rdata_q[STAT_HIGHZ_BIT]  <= high_impedance_input_mode_i;
        end else if (reg_addr_i == ADDR_FLAG) begin
          rdata_q[FLAG_DONE_BIT] <= done_flag_q;
        end else if (reg_addr_i == ADDR_MASK) begin
          rdata_q[MASK_DONE_BIT] <= done_mask_q;
        end else if (reg_addr_i >= ADDR_RESULT
                     && reg_addr_i < ADDR_RESULT + ADDR_W'(NUM_CH)) begin
          rdata_q <= res_q[CH_W'(reg_addr_i - ADDR_RESULT)];
        end
      end
    end
  end

  assign reg_rdata_o = rdata_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  a_oneshot_clear: assert property (pass_end && oneshot_q && !wr_ctrl |=> !conv_en_q)
    else $error("one-shot pass end left enable set");
  a_cont_no_done: assert property (!oneshot_q && !$past(oneshot_q) |-> !done_stat_q)
    else $error("done status set in continuous mode");
  a_gate_start: assert property (conv_start_o |-> run_ok && !pause_q && conv_en_q)
    else $error("conversion started without valid supply");
  a_auto_start: assert property (state_q == ST_START && conv_en_q && $rose(run_ok)
                                 && !pause_q |-> conv_start_o ##1 state_q == ST_WAIT)
    else $error("no start once supply became valid");
  a_speed_redo: assert property (state_q == ST_WAIT && conv_en_q && !hold
                                 && speed_q != run_speed_q
                                 |-> conv_abort_o ##1 (state_q == ST_START
                                     && $stable(conv_chan_o)))
    else $error("speed change did not redo channel");
  a_sw_stop: assert property (!conv_en_q |-> !conv_start_o)
    else $error("conversion started while disabled");
  a_plug_pause: assert property (adapter_plugin_i |=> pause_q && !conv_start_o)
    else $error("conversion during plug-in pause");
  a_flag_set: assert property (done_set |=> done_flag_q && done_stat_q)
    else $error("done flag not set on status edge");
  a_flag_clear: assert property (reg_rd_i && reg_addr_i == ADDR_FLAG && !done_set
                                 |=> !done_flag_q)
    else $error("done flag survived read");
  a_int_fire: assert property (done_set && !done_mask_q && int_n_o |=> !int_n_o)
    else $error("unmasked done gave no pulse");
  a_bias_ts: assert property (conv_en_q && !chan_dis_q[THERM_CH]
                              |-> internal_bias_regulator_en_o)
    else $error("bias regulator off with thermistor channel");

  c_oneshot_pass: cover property (oneshot_q && pass_end ##1 done_stat_q);
  c_speed_redo: cover property (state_q == ST_WAIT && speed_q != run_speed_q ##1 conv_start_o);
  c_plug_pause: cover property (state_q == ST_WAIT && adapter_plugin_i ##1 conv_abort_o);
  c_int_pulse: cover property ($fell(int_n_o));

endmodule : adc_monitor_ctrl
`default_nettype wire

// File: tb/adc_monitor_ctrl_tb_top.sv
// self-checking bench for the monitor converter control
// assumes rtl/adc_monitor_pkg.sv and the design modules are compiled first
`timescale 1ns/1ps
`default_nettype none

module adc_monitor_ctrl_tb_top;
  import adc_monitor_pkg::*;
  localparam int PCYC = 8;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic              ac_ok = 1'b1;
  logic              bus_ok = 1'b0;
  logic              bat_lo = 1'b0;
  logic              bat_hi = 1'b0;
  logic              plug = 1'b0;
  logic              setup_done = 1'b0;
  logic              cdone = 1'b0;
  logic [RES_W-1:0]  cdata = '0;
  logic              start;
  logic              abort;
  logic [2:0]        chan;
  logic [1:0]        speed;
  logic              pwr;
  logic              bias;
  logic              int_n;
  logic [15:0]       v;
  logic              hit;
  int                cnt;
  int                err_count = 0;
  int                checks = 0;

  always #4 clk = ~clk;

  adc_monitor_ctrl #(.PULSE_CYC(PCYC)) i_adc_monitor_ctrl (
    .sys_clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .ac_valid_i(ac_ok),
    .bus_valid_i(bus_ok), .bat_above_low_i(bat_lo), .bat_above_high_i(bat_hi),
    .high_impedance_input_mode_i(1'b1), .adapter_plugin_i(plug),
    .input_setup_done_i(setup_done), .battery_only_i(1'b0),
    .charge_current_zero_i(1'b0), .conv_start_o(start), .conv_abort_o(abort),
    .conv_chan_o(chan), .sample_speed_o(speed), .conv_done_i(cdone),
    .conv_data_i(cdata), .adc_power_en_o(pwr), .internal_bias_regulator_en_o(bias),
    .current_sense_amp_en_o(), .int_n_o(int_n));

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk

  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk) begin wr <= 1'b1; addr <= a; wdata <= d; end
    @(posedge clk) wr <= 1'b0;
  endtask : wreg

  task automatic rreg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk) begin rd <= 1'b1; addr <= a; end
    @(posedge clk) rd <= 1'b0;
    #1 d = rdata;
  endtask : rreg

  task automatic wait_start(input int n);
    hit = 1'b0;
    repeat (n) begin
      @(negedge clk);
      if (start === 1'b1) begin
        hit = 1'b1;
        break;
      end
    end
  endtask : wait_start

  // finish the running conversion and count low cycles of the notification
  task automatic finish(input logic [15:0] d);
    @(posedge clk) begin cdone <= 1'b1; cdata <= d; end
    @(posedge clk) cdone <= 1'b0;
    cnt = 0;
    repeat (14) begin
      #1 if (int_n === 1'b0) cnt++;
      @(posedge clk);
    end
  endtask : finish

  task automatic t_reset;
    rreg(ADDR_CTRL, v);   chk("ctrl reset", v, CTRL_RESET);
    rreg(ADDR_CHAN_DIS, v); chk("chan_dis reset", v, CHAN_DIS_RESET);
    rreg(ADDR_RESULT, v); chk("result reset", v, RESULT_RESET);
    rreg(8'h7F, v);       chk("unmapped read", v, 16'h0000);
  endtask : t_reset

  task automatic t_oneshot(input logic masked);
    wreg(ADDR_MASK, {15'h0000, masked});
    wreg(ADDR_CHAN_DIS, 16'h00FE);
    wreg(ADDR_CTRL, 16'h0003);
    wait_start(20);
    chk("oneshot start", {15'h0000, hit}, 16'h0001);
    chk("oneshot chan", {13'h0000, chan}, 16'h0000);
    finish(16'hA5C3);
    chk("int low cycles", cnt[15:0], masked ? 16'h0000 : PCYC[15:0]);
    rreg(ADDR_RESULT, v); chk("result ch0", v, 16'hA5C3);
    rreg(ADDR_CTRL, v);   chk("enable self clear", v, 16'h0002);
    rreg(ADDR_STATUS, v); chk("done status", {15'h0000, v[STAT_DONE_BIT]}, 16'h0001);
    rreg(ADDR_FLAG, v);   chk("done flag", v, 16'h0001);
    rreg(ADDR_FLAG, v);   chk("flag cleared", v, 16'h0000);
    chk("power off", {15'h0000, pwr}, 16'h0000);
  endtask : t_oneshot

  task automatic t_gating;
    @(posedge clk) ac_ok <= 1'b0;
    repeat (4) @(posedge clk);
    wreg(ADDR_CTRL, 16'h0003);
    wait_start(20);
    chk("no supply no start", {15'h0000, hit}, 16'h0000);
    @(posedge clk) bus_ok <= 1'b1;
    wait_start(20);
    chk("deferred start", {15'h0000, hit}, 16'h0001);
    finish(16'h1234);
    @(posedge clk) plug <= 1'b1;
    @(posedge clk) plug <= 1'b0;
    wreg(ADDR_CTRL, 16'h0003);
    wait_start(20);
    chk("paused on plug", {15'h0000, hit}, 16'h0000);
    @(posedge clk) setup_done <= 1'b1;
    @(posedge clk) setup_done <= 1'b0;
    wait_start(20);
    chk("resume after setup", {15'h0000, hit}, 16'h0001);
    finish(16'h4321);
    rreg(ADDR_FLAG, v);
    chk("gating done flag", v, 16'h0001);
    @(posedge clk) ac_ok <= 1'b1;
  endtask : t_gating

  task automatic t_speed;
    wreg(ADDR_CTRL, 16'h0001);
    wait_start(20);
    wreg(ADDR_CTRL, 16'h0021);
    wait_start(20);
    chk("restart after speed", {15'h0000, hit}, 16'h0001);
    chk("same channel", {13'h0000, chan}, 16'h0000);
    chk("new speed", {14'h0000, speed}, 16'h0002);
    finish(16'h0F0F);
    chk("no int continuous", cnt[15:0], 16'h0000);
    rreg(ADDR_FLAG, v); chk("flag zero continuous", v, 16'h0000);
    wreg(ADDR_CTRL, 16'h0000);
  endtask : t_speed

  task automatic t_average;
    wreg(ADDR_CTRL, 16'h0007);
    wait_start(20);
    finish(16'h0101);
    rreg(ADDR_RESULT, v);
    chk("average with stored", v, 16'h0808);
    wreg(ADDR_CTRL, 16'h0000);
    wreg(ADDR_CTRL, 16'h000F);
    wait_start(20);
    finish(16'h0202);
    rreg(ADDR_RESULT, v);
    chk("fresh seed raw", v, 16'h0202);
  endtask : t_average

  task automatic t_bias;
    wreg(ADDR_CHAN_DIS, 16'h00BF);
    wreg(ADDR_CTRL, 16'h0001);
    #1 chk("bias forced on", {15'h0000, bias}, 16'h0001);
    wreg(ADDR_CHAN_DIS, 16'h00FF);
    #1 chk("bias off", {15'h0000, bias}, 16'h0000);
    finish(16'h00C6);
    rreg(ADDR_STATUS, v);
    chk("idle after all off", {15'h0000, v[STAT_BUSY_BIT]}, 16'h0000);
    rreg(ADDR_RESULT + 8'h06, v);
    chk("finished while disabled", v, 16'h00C6);
    wreg(ADDR_CTRL, 16'h0000);
  endtask : t_bias

  task automatic t_battery;
    @(posedge clk) begin ac_ok <= 1'b0; bus_ok <= 1'b0; bat_lo <= 1'b1; end
    wreg(ADDR_CHAN_DIS, 16'h00BF);
    wreg(ADDR_CTRL, 16'h0003);
    wait_start(20);
    chk("thermistor needs high battery", {15'h0000, hit}, 16'h0000);
    @(posedge clk) bat_hi <= 1'b1;
    wait_start(20);
    chk("start on high battery", {15'h0000, hit}, 16'h0001);
    chk("thermistor channel", {13'h0000, chan}, 16'h0006);
    wreg(ADDR_CTRL, 16'h0000);
  endtask : t_battery

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_reset();
    t_oneshot(1'b0);
    t_oneshot(1'b1);
    t_gating();
    t_speed();
    t_average();
    t_bias();
    t_battery();
    tally_and_finish();
  end

  initial begin
    #200us;
    err_count++;
    tally_and_finish();
  end
endmodule : adc_monitor_ctrl_tb_top

`default_nettype wire
